// File: pqm_ctrl.v
// Port queue map and policing control bank with its per-packet decision path.
// Assumes a single-cycle register port and one packet descriptor per cycle at most.
//
// The implementer's own choice: strobed register access.
`include "pqm_regs.vh"

module pqm_ctrl (
  input wire sys_clk,
  input wire reset_n,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire pkt_valid,
  input wire [1:0] pkt_port,
  input wire [2:0] pkt_prio,
  input wire pkt_is_ip,
  input wire [1:0] pkt_dscp_color,
  input wire [1:0] pkt_remap_color,
  input wire [1:0] pkt_meter_color,
  input wire pkt_srp,
  input wire pm_over_max,
  input wire pm_prob_drop,
  output reg dec_valid,
  output reg [1:0] dec_queue,
  output reg [1:0] dec_color,
  output reg dec_drop,
  output reg dec_mark
);

  localparam NUM_ENT = 12;
  localparam NUM_CNT = 48;
  localparam [31:0] MAP_RST = `PQM_MAP_RESET;

  // Read data path states, one-hot.
  localparam RD_IDLE = 2'b01;
  localparam RD_DATA = 2'b10;

  // Entry index of a port and queue pair.
  function [3:0] ent_idx;
    input [2:0] port;
    input [1:0] queue;
    begin
      ent_idx = {port[1:0], queue};
    end
  endfunction

  // Only ports zero to two own storage; higher indexes are unbacked.
  function port_ok;
    input [2:0] port;
    begin
      port_ok = (port < `PQM_NUM_PORTS);
    end
  endfunction

  reg [2:0] port_idx_q;
  reg [1:0] queue_ptr_q;
  reg [1:0] map_q [0:7];
  reg [11:0] pol_q [0:NUM_ENT-1];
  reg [15:0] cnt_q [0:NUM_CNT-1];
  reg [1:0] rd_state_q;
  reg [31:0] rd_hold_q;

  reg dec_act_q;
  reg [3:0] dec_ent_q;

  wire wr_ptr;
  wire wr_map;
  wire wr_pol;
  wire ptr_ok;
  wire [3:0] ptr_ent;
  wire [11:0] ptr_pol;
  wire [1:0] pkt_queue;
  wire aggr_mode;
  wire [2:0] pkt_pol_port;
  wire [3:0] pkt_ent;
  wire pkt_ok;
  wire [11:0] pkt_ctrl;
  wire dp_active;
  wire [1:0] dp_color;
  wire dp_drop;
  wire dp_mark;
  wire [31:0] map_word;

  // Write decode; an unmapped address takes no write.
  assign wr_ptr = reg_wr && (reg_addr == `PQM_PTR_OFS);
  assign wr_map = reg_wr && (reg_addr == `PQM_MAP_OFS);
  assign wr_pol = reg_wr && (reg_addr == `PQM_POL_OFS);

  // The pointer selects the indirect entry that police accesses reach.
  assign ptr_ok = port_ok(port_idx_q);
  assign ptr_ent = ent_idx(port_idx_q, queue_ptr_q);
  assign ptr_pol = ptr_ok ? pol_q[ptr_ent] : 12'h000;

  // Pointer register: only the port index and queue pointer are stored.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_idx_q <= 3'h0;
      queue_ptr_q <= 2'h0;
    end else if (wr_ptr) begin
      port_idx_q <= reg_wdata[`PQM_PTR_PORT_HI:`PQM_PTR_PORT_LO];
      queue_ptr_q <= reg_wdata[`PQM_PTR_QUEUE_HI:`PQM_PTR_QUEUE_LO];
    end
  end

  // Priority map: the two reserved bits of each nibble are not kept.
  genvar p;
  generate
    for (p = 0; p < 8; p = p + 1) begin : g_map
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          map_q[p] <= MAP_RST[4*p +: 2];
        end else if (wr_map) begin
          map_q[p] <= reg_wdata[4*p +: 2];
        end
      end
      assign map_word[4*p +: 4] = {2'b00, map_q[p]};
    end
  endgenerate

  // Police control storage, one entry per port and queue.
  // A write with an unbacked port index is dropped rather than aliased.
  genvar e;
  generate
    for (e = 0; e < NUM_ENT; e = e + 1) begin : g_pol
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          pol_q[e] <= `PQM_POL_RESET;
        end else if (wr_pol && ptr_ok && (ptr_ent == e)) begin
          pol_q[e] <= reg_wdata[11:0];
        end
      end
    end
  endgenerate

  // Egress queue of the arriving packet.
  assign pkt_queue = map_q[pkt_prio];

  // Port zero's entry of the queue decides between per-port and aggregated policing.
  assign aggr_mode = !pol_q[ent_idx(3'h0, pkt_queue)][`PQM_POL_PORT_BASED];
  assign pkt_pol_port = aggr_mode ? 3'h0 : {1'b0, pkt_port};
  assign pkt_ok = port_ok(pkt_pol_port);
  assign pkt_ent = ent_idx(pkt_pol_port, pkt_queue);
  assign pkt_ctrl = pkt_ok ? pol_q[pkt_ent] : 12'h000;

  // Decision logic for the selected entry.
  pqm_police_dec u_dec (
    .ctrl(pkt_ctrl),
    .is_ip(pkt_is_ip),
    .dscp_color(pkt_dscp_color),
    .remap_color(pkt_remap_color),
    .meter_color(pkt_meter_color),
    .srp(pkt_srp),
    .pm_over_max(pm_over_max),
    .pm_prob_drop(pm_prob_drop),
    .active(dp_active),
    .color(dp_color),
    .drop(dp_drop),
    .mark(dp_mark)
  );

  // Decision outputs are registered so they stand one clean cycle.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_valid <= 1'b0;
      dec_queue <= 2'h0;
      dec_color <= 2'h0;
      dec_drop <= 1'b0;
      dec_mark <= 1'b0;
      dec_act_q <= 1'b0;
      dec_ent_q <= 4'h0;
    end else begin
      dec_valid <= pkt_valid;
      if (pkt_valid) begin
        dec_queue <= pkt_queue;
        dec_color <= dp_color;
        dec_drop <= dp_drop;
        dec_mark <= dp_mark;
        dec_act_q <= dp_active && pkt_ok;
        dec_ent_q <= pkt_ent;
      end
    end
  end

  // Packet monitor counters: per entry one dropped count and three color counts.
  // Counters saturate rather than wrap so a reading never falls below an earlier one.
  genvar c;
  generate
    for (c = 0; c < NUM_CNT; c = c + 1) begin : g_cnt
      wire hit_ent;
      wire hit;
      assign hit_ent = dec_valid && dec_act_q && (dec_ent_q == (c / 4));
      if ((c % 4) == 0) begin : g_drop
        assign hit = hit_ent && dec_drop;
      end else begin : g_color
        assign hit = hit_ent && (dec_color == (c % 4)) &&
                     (!pol_q[c/4][`PQM_POL_DROPPED_COLOR] || dec_drop);
      end
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          cnt_q[c] <= 16'h0000;
        end else if (hit && (cnt_q[c] != `PQM_CNT_MAX)) begin
          cnt_q[c] <= cnt_q[c] + 16'h0001;
        end
      end
    end
  endgenerate

  // Read mux; unmapped addresses and reserved bits read as zero.
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (reg_addr)
      `PQM_PTR_OFS: begin
        rd_mux[`PQM_PTR_PORT_HI:`PQM_PTR_PORT_LO] = port_idx_q;
        rd_mux[`PQM_PTR_QUEUE_HI:`PQM_PTR_QUEUE_LO] = queue_ptr_q;
      end
      `PQM_MAP_OFS: begin
        rd_mux = map_word;
      end
      `PQM_POL_OFS: begin
        rd_mux[11:0] = ptr_pol;
      end
      `PQM_CNT_OFS: begin
        if (ptr_ok) begin
          rd_mux[15:0] = cnt_q[{ptr_ent, ptr_pol[`PQM_POL_PTYPE_HI:`PQM_POL_PTYPE_LO]}];
        end
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe and is zero otherwise.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_state_q <= RD_IDLE;
      rd_hold_q <= 32'h00000000;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          if (reg_rd) begin
            rd_state_q <= RD_DATA;
            rd_hold_q <= rd_mux;
          end
        end
        RD_DATA: begin
          if (reg_rd) begin
            rd_hold_q <= rd_mux;
          end else begin
            rd_state_q <= RD_IDLE;
            rd_hold_q <= 32'h00000000;
          end
        end
        default: begin
          rd_state_q <= RD_IDLE;
          rd_hold_q <= 32'h00000000;
        end
      endcase
    end
  end

  // Output copy of the held read word.
  always @* begin
    reg_rdata = rd_hold_q;
  end

endmodule // pqm_ctrl

// File: pqm_regs.vh
// Offsets, field positions, reset values and encodings of the port queue map and policing bank.
// Assumes a 16-bit byte address on the register port and 32-bit read and write data.
// How it works
// - Port index picks one of three ports
// - Queue pointer picks one of four queues
// - Nibble p low bits give priority p queue
// - Reset map: 7,6>3 5,4>2 3,2>1 1,0>0
// - Dropped-color bit limits color counts to drops
// - Drop-all drops everything above maximum threshold
// - Packet type selects which count reads back
// - Clear port-based bit polices per queue via port zero
// - Color-aware non-IP frames take the configured color
// - Color marking only while mark enable set
// - Remap bit remaps DSCP color, else direct
// - SRP packets droppable only with drop-SRP set
// - Police mode: one blind, zero aware
// - Police enable gates policing and WRED, resets zero
`ifndef PQM_REGS_VH
`define PQM_REGS_VH

// Register byte offsets.
`define PQM_PTR_OFS 16'h0804
`define PQM_MAP_OFS 16'h0808
`define PQM_POL_OFS 16'h080c
`define PQM_CNT_OFS 16'h0810

// Pointer register fields.
`define PQM_PTR_PORT_HI 18
`define PQM_PTR_PORT_LO 16
`define PQM_PTR_QUEUE_HI 1
`define PQM_PTR_QUEUE_LO 0
`define PQM_NUM_PORTS 3'h3

// Priority map reset value, two used bits per nibble.
`define PQM_MAP_RESET 32'h33221100

// Police control fields and reset value.
`define PQM_POL_WIDTH 12
`define PQM_POL_RESET 12'h020
`define PQM_POL_DROPPED_COLOR 11
`define PQM_POL_DROP_ALL 10
`define PQM_POL_PTYPE_HI 9
`define PQM_POL_PTYPE_LO 8
`define PQM_POL_PORT_BASED 7
`define PQM_POL_NONIP_HI 6
`define PQM_POL_NONIP_LO 5
`define PQM_POL_MARK_EN 4
`define PQM_POL_REMAP_EN 3
`define PQM_POL_DROP_SRP 2
`define PQM_POL_BLIND 1
`define PQM_POL_ENABLE 0

// Colors share their codes with the packet type field.
`define PQM_TYPE_DROPPED 2'h0
`define PQM_COLOR_GREEN 2'h1
`define PQM_COLOR_YELLOW 2'h2
`define PQM_COLOR_RED 2'h3

// Packet monitor counters.
`define PQM_CNT_WIDTH 16
`define PQM_CNT_MAX 16'hffff

`endif

// File: pqm_police_dec.v
// Per-packet policing and WRED decision for one control entry.
// Assumes the meter color and WRED drop inputs come from logic outside this bank.
`include "pqm_regs.vh"

module pqm_police_dec (
  input wire [11:0] ctrl,
  input wire is_ip,
  input wire [1:0] dscp_color,
  input wire [1:0] remap_color,
  input wire [1:0] meter_color,
  input wire srp,
  input wire pm_over_max,
  input wire pm_prob_drop,
  output reg active,
  output reg [1:0] color,
  output reg drop,
  output reg mark
);

  reg [1:0] in_color;
  reg wred_hit;

  // The worse of the incoming color and the meter color wins, as codes grow with severity.
  always @* begin
    active = ctrl[`PQM_POL_ENABLE];
    if (ctrl[`PQM_POL_BLIND]) begin
      in_color = `PQM_COLOR_GREEN;
    end else if (!is_ip) begin
      in_color = ctrl[`PQM_POL_NONIP_HI:`PQM_POL_NONIP_LO];
    end else if (ctrl[`PQM_POL_REMAP_EN]) begin
      in_color = remap_color;
    end else begin
      in_color = dscp_color;
    end
    wred_hit = ctrl[`PQM_POL_DROP_ALL] ? pm_over_max : pm_prob_drop;
    if (!active) begin
      color = `PQM_COLOR_GREEN;
      drop = 1'b0;
      mark = 1'b0;
    end else begin
      color = (meter_color > in_color) ? meter_color : in_color;
      drop = wred_hit && (!srp || ctrl[`PQM_POL_DROP_SRP]);
      mark = ctrl[`PQM_POL_MARK_EN];
    end
  end

endmodule // pqm_police_dec

// File: pqm_ctrl_props.sv
// Checker for the policing bank: read-back masks and decision timing.
// Assumes it is bound to pqm_ctrl and sees only its ports.
`include "pqm_regs.vh"
module pqm_ctrl_props (
  input wire sys_clk,
  input wire reset_n,
  input wire [15:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire pkt_valid,
  input wire pm_over_max,
  input wire pm_prob_drop,
  input wire dec_valid,
  input wire dec_drop
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Address decode of a read; any other address must answer zero.
  wire rd_ptr = reg_rd && reg_addr == `PQM_PTR_OFS;
  wire rd_map = reg_rd && reg_addr == `PQM_MAP_OFS;
  wire rd_pol = reg_rd && reg_addr == `PQM_POL_OFS;
  wire rd_cnt = reg_rd && reg_addr == `PQM_CNT_OFS;

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero while idle");
  unmapped_zero_a: assert property (reg_rd && !(rd_ptr || rd_map || rd_pol || rd_cnt) |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  ptr_reserved_a: assert property (rd_ptr |=> (reg_rdata & 32'hfff8fffc) == 32'h0)
    else $error("pointer reserved bits set");
  map_upper_a: assert property (rd_map |=> (reg_rdata & 32'hcccccccc) == 32'h0)
    else $error("map reserved bits set");
  pol_reserved_a: assert property (rd_pol |=> reg_rdata[31:12] == 20'h0)
    else $error("control reserved bits set");
  cnt_width_a: assert property (rd_cnt |=> reg_rdata[31:16] == 16'h0)
    else $error("count upper bits set");
  dec_follow_a: assert property (pkt_valid |=> dec_valid)
    else $error("decision missing");
  dec_cause_a: assert property (dec_valid |-> $past(pkt_valid))
    else $error("decision without packet");
  drop_cause_a: assert property (dec_valid && dec_drop |-> $past(pm_over_max || pm_prob_drop))
    else $error("drop without cause");
endmodule // pqm_ctrl_props

bind pqm_ctrl pqm_ctrl_props chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pkt_valid(pkt_valid), .pm_over_max(pm_over_max), .pm_prob_drop(pm_prob_drop),
  .dec_valid(dec_valid), .dec_drop(dec_drop));

// File: testbench.sv
// Self-checking bench for the port queue map and policing bank.
// Assumes pqm_ctrl answers reads and packets exactly one cycle later.
`include "pqm_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // Reset starts unknown so that its first drive to zero is a real falling edge for the design.
  logic reset_n;
  logic sys_clk = 0, reg_wr = 0, reg_rd = 0, pkt_valid = 0, pkt_is_ip = 0, pkt_srp = 0;
  logic pm_over_max = 0, pm_prob_drop = 0, dec_valid, dec_drop, dec_mark;
  logic [15:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, rv, m, c;
  logic [1:0] pkt_port = 0, pkt_dscp_color = 0, pkt_remap_color = 0, pkt_meter_color = 0, dec_queue, dec_color;
  logic [2:0] pkt_prio = 0;
  int n_fail = 0, checks = 0, i;

  pqm_ctrl dut_u (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pkt_valid,
    .pkt_port, .pkt_prio, .pkt_is_ip, .pkt_dscp_color, .pkt_remap_color, .pkt_meter_color, .pkt_srp,
    .pm_over_max, .pm_prob_drop, .dec_valid, .dec_queue, .dec_color, .dec_drop, .dec_mark);

  // Free-running 100 MHz clock.
  initial forever #5 sys_clk = ~sys_clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe, so sample just past that edge.
  task rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // One packet; its fields stay put afterwards so the expectation can use them.
  task pk(input logic [1:0] port, input logic [2:0] prio, input logic [9:0] f);
    @(posedge sys_clk);
    pkt_valid <= 1'b1;
    pkt_port <= port;
    pkt_prio <= prio;
    {pkt_is_ip, pkt_dscp_color, pkt_remap_color, pkt_meter_color, pkt_srp, pm_over_max, pm_prob_drop} <= f;
    @(posedge sys_clk);
    pkt_valid <= 1'b0;
    #1 chk(dec_valid, 1);
  endtask

  // Expected {color, drop, mark} for control word c and the current packet fields.
  function logic [3:0] dec_exp(input logic [11:0] c);
    logic [1:0] ic;
    if (!c[0]) return 4'h4;
    ic = c[1] ? 2'h1 : !pkt_is_ip ? c[6:5] : c[3] ? pkt_remap_color : pkt_dscp_color;
    ic = (ic > pkt_meter_color) ? ic : pkt_meter_color;
    return {ic, (c[10] ? pm_over_max : pm_prob_drop) & (!pkt_srp | c[2]), c[4]};
  endfunction

  // Hang guard; every other wait in the bench is a fixed count.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    end_sim;
  end

  // Main sequence.
  initial begin
    reset_n <= 1'b0;
    i = $urandom(32'hde68);
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`PQM_MAP_OFS, rv);
    chk(rv, 32'h33221100);
    rd(`PQM_POL_OFS, rv);
    chk(rv, 32'h20);
    rd(16'h0800, rv);
    chk(rv, 0);
    $display("reset test done");
    m = $urandom;
    wr(`PQM_MAP_OFS, m);
    rd(`PQM_MAP_OFS, rv);
    chk(rv, m & 32'h33333333);
    for (i = 0; i < 8; i++) begin
      pk(2'(i % 3), 3'(i), 10'($urandom));
      chk(dec_queue, m[4 * i +: 2]);
      chk({dec_color, dec_drop, dec_mark}, 4'h4);
    end
    $display("map test done");
    c = $urandom;
    wr(`PQM_PTR_OFS, c);
    rd(`PQM_PTR_OFS, rv);
    chk(rv, c & 32'h00070003);
    wr(`PQM_MAP_OFS, 0);
    wr(`PQM_PTR_OFS, 0);
    // Random control words with the per-queue mode, so port 0's entry governs every port.
    for (i = 0; i < 40; i++) begin
      c = $urandom & 32'hffffff7f;
      wr(`PQM_POL_OFS, c);
      rd(`PQM_POL_OFS, rv);
      chk(rv, c & 32'hf7f);
      pk(2'($urandom % 3), 3'($urandom), 10'($urandom));
      chk({dec_color, dec_drop, dec_mark}, dec_exp(c[11:0]));
    end
    $display("police test done");
    wr(`PQM_POL_OFS, 32'h80);
    wr(`PQM_PTR_OFS, 32'h10000);
    wr(`PQM_POL_OFS, 32'h11);
    pk(2'd1, 3'd0, 10'h0);
    chk(dec_mark, 1);
    pk(2'd0, 3'd0, 10'h0);
    chk(dec_mark, 0);
    $display("port mode test done");
    wr(`PQM_PTR_OFS, 32'h20000);
    wr(`PQM_POL_OFS, 32'h103);
    repeat (3) pk(2'd2, 3'd0, 10'h8);
    pk(2'd2, 3'd0, 10'h9);
    rd(`PQM_CNT_OFS, rv);
    chk(rv, 4);
    wr(`PQM_POL_OFS, 32'h903);
    pk(2'd2, 3'd0, 10'h8);
    pk(2'd2, 3'd0, 10'h9);
    rd(`PQM_CNT_OFS, rv);
    chk(rv, 5);
    wr(`PQM_POL_OFS, 32'h003);
    rd(`PQM_CNT_OFS, rv);
    chk(rv, 2);
    wr(`PQM_POL_OFS, 32'h303);
    rd(`PQM_CNT_OFS, rv);
    chk(rv, 0);
    $display("count test done");
    end_sim;
  end
endmodule // testbench
